//--- verilog/cfs_defs.vh
// Purpose: Shared constants for the character field scan unit.
// Assumes: 6-bit characters, 12-bit count field, 15-bit index registers.
// Notes:   Included by the scan unit; definitions only.
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

// Operand widths
`define CFS_CHAR_W        6
`define CFS_CNT_W         12
`define CFS_XREG_W        15
`define CFS_SEL_W         2

// Index select flag codes
`define CFS_SEL_NONE      2'h0
`define CFS_SEL_FIRST     2'h1
`define CFS_SEL_SECOND    2'h2
`define CFS_SEL_FIRST_ALT 2'h3

// Exit offsets from the instruction address
`define CFS_EXIT_MISS     3
`define CFS_EXIT_HIT      4

// Zero character code and the codes that must never count as one
`define CFS_ZERO_CHAR     6'h00
`define CFS_NOT_ZERO_A    6'h0a
`define CFS_NOT_ZERO_B    6'h1a
`define CFS_NOT_ZERO_C    6'h2a

// State codes
`define CFS_ST_IDLE       2'h0
`define CFS_ST_READ       2'h1
`define CFS_ST_WAIT       2'h2
`define CFS_ST_DONE       2'h3

`endif

//--- verilog/cfs_scan.v
// Purpose: Execution logic of the character field scan instructions.
// Assumes: Storage answers each one-cycle read request with a one-cycle
//          acknowledge carrying the character, on the same clock.
// Notes:   One scan at a time; start is ignored while busy.
`timescale 1ns/1ns
`include "cfs_defs.vh"

// Function
// R1: Start address is instruction address field plus selected index register.
// R2: Select 1 or 3 uses first index, 2 uses second, 0 none.
// R3: Scan character is six bits, compared with every searched character.
// R4: Equality search stops on equal character, continues at P plus 4.
// R5: Whole field searched without a find continues at P plus 3.
// R6: Program zeroes second word bits 00-18, third word bits 12-17.
// R7: Delimited forms: program zeroes second word bits 00-18 only.
// R8: On a find, characters searched go to low 12 count bits.
// R9: After a failed search the count equals the search length.
// R10: Upper three count bits are undefined; this unit writes zero there.
// R11: Octal codes 12, 32 and 52 never equal a zero scan character.
// R12: Delimited form stops on delimiting character and exits at P plus 3.
// R13: Scan find and delimit find together: scan wins, exit P plus 4.
// R14: Inequality forms exit P plus 4 on first unequal, else P plus 3.
// R15: Stop at first qualifying character, address moves one per compare.
module cfs_scan #(
  parameter AW = 20,
  parameter PW = 18
) (
  // Clock and reset
  input  wire                      clk,
  input  wire                      nrst,
  // Instruction operands from sequencing
  input  wire                      start,
  input  wire [PW-1:0]             instr_addr,
  input  wire [AW-1:0]             field_addr,
  input  wire [`CFS_SEL_W-1:0]     index_select_flag,
  input  wire [`CFS_XREG_W-1:0]    first_index_reg,
  input  wire [`CFS_XREG_W-1:0]    second_index_reg,
  input  wire [`CFS_CHAR_W-1:0]    scan_char,
  input  wire [`CFS_CHAR_W-1:0]    delimit_char,
  input  wire [`CFS_CNT_W-1:0]     search_len,
  input  wire                      left_to_right,
  input  wire                      unequal_test,
  input  wire                      delimited,
  // Character storage
  output reg                       mem_req,
  output reg  [AW-1:0]             mem_addr,
  input  wire                      mem_ack,
  input  wire [`CFS_CHAR_W-1:0]    mem_rdata,
  // Results to sequencing
  output reg                       busy,
  output reg                       next_instr_fetch,
  output reg  [PW-1:0]             next_addr,
  output reg                       count_we,
  output reg  [`CFS_XREG_W-1:0]    count_index_reg,
  output reg                       found
);

  localparam [1:0] ST_IDLE = `CFS_ST_IDLE;
  localparam [1:0] ST_READ = `CFS_ST_READ;
  localparam [1:0] ST_WAIT = `CFS_ST_WAIT;
  localparam [1:0] ST_DONE = `CFS_ST_DONE;
  localparam [PW-1:0] OFS_MISS = `CFS_EXIT_MISS;
  localparam [PW-1:0] OFS_HIT  = `CFS_EXIT_HIT;

  // Latched operands and scan progress
  reg  [1:0]                state;
  reg  [PW-1:0]             p_addr;
  reg  [`CFS_CHAR_W-1:0]    scan_q;
  reg  [`CFS_CHAR_W-1:0]    delim_q;
  reg  [`CFS_CNT_W-1:0]     len;
  reg  [`CFS_CNT_W-1:0]     done_cnt;
  reg                       dir_up;
  reg                       want_unequal;
  reg                       use_delim;
  reg                       hit;

  // Next values
  reg  [1:0]                next_state;
  reg  [AW-1:0]             next_mem_addr;
  reg                       next_mem_req;
  reg  [`CFS_CNT_W-1:0]     next_done_cnt;
  reg                       next_hit;
  reg                       next_busy;
  reg                       next_fetch;
  reg                       next_count_we;
  reg  [PW-1:0]             next_next_addr;
  reg  [`CFS_XREG_W-1:0]    next_count;

  // Selected index and starting address
  reg  [`CFS_XREG_W-1:0]    index_val;
  wire [AW-1:0]             start_addr;

  // Compare terms on the returned character and the scan position
  wire                      char_eq;
  wire                      delim_eq;
  wire                      scan_find;
  wire                      delim_find;
  wire                      last_char;

  // Index register choice; code 3 aliases the first register.
  // The index is read only in the start cycle, so a change of the
  // index registers while a scan runs leaves its addresses alone.
  // All four codes are decoded; the default also keeps it latch-free.
  always @* begin
    case (index_select_flag)
      `CFS_SEL_FIRST:     index_val = first_index_reg;   // R2
      `CFS_SEL_FIRST_ALT: index_val = first_index_reg;   // R2
      `CFS_SEL_SECOND:    index_val = second_index_reg;  // R2
      default:            index_val = {`CFS_XREG_W{1'b0}}; // R2
    endcase
  end

  // Index is zero-extended; sum wraps within the address space
  assign start_addr = field_addr + {{(AW-`CFS_XREG_W){1'b0}}, index_val}; // R1

  // Per-bit compare of the returned character with both operands
  genvar                    gi;
  wire [`CFS_CHAR_W-1:0]    scan_bit_eq;
  wire [`CFS_CHAR_W-1:0]    delim_bit_eq;
  wire                      zone_only;
  generate
    for (gi = 0; gi < `CFS_CHAR_W; gi = gi + 1) begin : g_cmp
      assign scan_bit_eq[gi]  = ~(mem_rdata[gi] ^ scan_q[gi]);  // R3
      assign delim_bit_eq[gi] = ~(mem_rdata[gi] ^ delim_q[gi]); // R12
    end
  endgenerate

  // Zone-only codes; the full compare already keeps them off zero,
  // the gate guards against a later narrowed compare
  assign zone_only = (mem_rdata == `CFS_NOT_ZERO_A) ||
                     (mem_rdata == `CFS_NOT_ZERO_B) ||
                     (mem_rdata == `CFS_NOT_ZERO_C);

  assign char_eq  = (&scan_bit_eq) &&
                    !(zone_only && scan_q == `CFS_ZERO_CHAR);  // R11
  assign delim_eq = (&delim_bit_eq) &&
                    !(zone_only && delim_q == `CFS_ZERO_CHAR);

  // Equal or unequal sense chosen by the instruction
  assign scan_find  = want_unequal ? !char_eq : char_eq;     // R14
  assign delim_find = use_delim && delim_eq;                 // R12
  assign last_char  = (done_cnt + 12'h001) == len;

  // Cycle plan of one scan, counted from the edge that takes start:
  //   +1     READ, busy high, first address already on mem_addr
  //   +2     mem_req pulse; the unit then waits in WAIT for mem_ack
  //   ack    the character is judged at the ack edge itself, so
  //          mem_rdata only has to stand beside mem_ack
  //   ack+1  DONE on a stop, else READ with the address moved
  //   DONE+1 exit pulse with address, count and outcome
  // A zero-length field goes straight to DONE and reads nothing.
  // There is no timeout on mem_ack: storage that never answers
  // leaves the unit busy until reset, as a lost storage cycle
  // would stop the processor anyway.
  // Start is taken in the exit cycle already (state is back to
  // idle), so back-to-back scans lose no cycle.

  // Sequencer: one storage read per character, stop on first find
  always @* begin
    next_state     = state;
    next_mem_addr  = mem_addr;
    next_mem_req   = 1'b0;
    next_done_cnt  = done_cnt;
    next_hit       = hit;
    next_busy      = busy;
    next_fetch     = 1'b0;
    next_count_we  = 1'b0;
    next_next_addr = next_addr;
    next_count     = count_index_reg;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_busy     = 1'b1;
          next_done_cnt = {`CFS_CNT_W{1'b0}};
          next_hit      = 1'b0;
          next_mem_addr = start_addr; // R1
          if (search_len == {`CFS_CNT_W{1'b0}}) begin
            // Empty field: nothing to read, plain miss
            next_state = ST_DONE;
          end else begin
            next_state = ST_READ;
          end
        end
      end
      ST_READ: begin
        next_mem_req = 1'b1;
        next_state   = ST_WAIT;
      end
      ST_WAIT: begin
        if (mem_ack) begin
          if (scan_find) begin
            // Scan find checked first so it beats a delimit find
            next_hit   = 1'b1; // R13
            next_state = ST_DONE; // R15
          end else if (delim_find) begin
            next_hit   = 1'b0; // R12
            next_state = ST_DONE;
          end else if (last_char) begin
            next_done_cnt = len;
            next_state    = ST_DONE; // R5
          end else begin
            next_done_cnt = done_cnt + 12'h001;
            // One character position per compare in the chosen direction
            if (dir_up) begin
              next_mem_addr = mem_addr + {{(AW-1){1'b0}}, 1'b1}; // R15
            end else begin
              next_mem_addr = mem_addr - {{(AW-1){1'b0}}, 1'b1}; // R15
            end
            next_state = ST_READ;
          end
        end
      end
      ST_DONE: begin
        next_busy     = 1'b0;
        next_fetch    = 1'b1;
        next_count_we = 1'b1;
        if (hit) begin
          next_next_addr = p_addr + OFS_HIT;  // R4
          // Count of characters passed before the find
          next_count = {3'h0, done_cnt};      // R8
        end else begin
          next_next_addr = p_addr + OFS_MISS; // R5
          // Full-field miss leaves the count equal to the field length; a delimit stop leaves its position
          next_count = {3'h0, done_cnt};      // R9
        end
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  // Delimit exit is a miss but the count shows where it stopped
  // Upper count bits are driven to zero for a defined value
  // (R10)

  // Operands are copied at start so sequencing may fetch on while
  // the scan runs; a few flops traded for no hold requirement.
  // Operand latch, taken only when a scan is accepted
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_addr  <= {PW{1'b0}};
      scan_q       <= {`CFS_CHAR_W{1'b0}};
      delim_q      <= {`CFS_CHAR_W{1'b0}};
      len          <= {`CFS_CNT_W{1'b0}};
      dir_up       <= 1'b1;
      want_unequal <= 1'b0;
      use_delim    <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      p_addr  <= instr_addr;
      scan_q       <= scan_char;      // R3
      delim_q      <= delimit_char;   // R12
      len          <= search_len;
      dir_up       <= left_to_right;  // R15
      want_unequal <= unequal_test;   // R14
      use_delim    <= delimited;
    end
  end

  // Every output is a flop, so sequencing may take the exit pulse
  // and the new address straight into its own next state without
  // a combinational path back through this unit.
  // State and output registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state            <= ST_IDLE;
      mem_req          <= 1'b0;
      mem_addr         <= {AW{1'b0}};
      done_cnt         <= {`CFS_CNT_W{1'b0}};
      hit              <= 1'b0;
      busy             <= 1'b0;
      next_instr_fetch <= 1'b0;
      next_addr        <= {PW{1'b0}};
      count_we         <= 1'b0;
      count_index_reg  <= {`CFS_XREG_W{1'b0}};
      found            <= 1'b0;
    end else begin
      state            <= next_state;
      mem_req          <= next_mem_req;
      mem_addr         <= next_mem_addr;
      done_cnt         <= next_done_cnt;
      hit              <= next_hit;
      busy             <= next_busy;
      next_instr_fetch <= next_fetch;
      next_addr        <= next_next_addr;
      count_we         <= next_count_we;
      count_index_reg  <= next_count; // R10
      // Outcome flag stands beside the exit address until the next scan's exit
      if (state == ST_DONE) begin
        found <= hit;
      end
    end
  end

endmodule

//--- test/cfs_scan_properties.sv
// Purpose: Port-level properties of the character field scan unit
// Assumes: Operands are latched here when a start is accepted
// Notes:   Top count bits are checked as this unit's chosen zero
`timescale 1ns/1ns
module cfs_scan_props #(
  parameter AW = 20,
  parameter PW = 18
) (
  // Clock, reset and operands
  input wire          clk,
  input wire          nrst,
  input wire          start,
  input wire          delimited,
  input wire [PW-1:0] instr_addr,
  input wire [AW-1:0] field_addr,
  input wire [1:0]    index_select_flag,
  input wire [14:0]   first_index_reg,
  input wire [14:0]   second_index_reg,
  input wire [11:0]   search_len,
  // Storage and results
  input wire          mem_req,
  input wire [AW-1:0] mem_addr,
  input wire          busy,
  input wire          next_instr_fetch,
  input wire [PW-1:0] next_addr,
  input wire          count_we,
  input wire [14:0]   count_index_reg,
  input wire          found
);
  reg  [PW-1:0] p_q;
  reg  [AW-1:0] r_q;
  reg  [11:0]   n_q;
  reg           d_q;
  wire [14:0]   ix = index_select_flag == 2'h2 ? second_index_reg :
                     index_select_flag == 2'h0 ? 15'h0 : first_index_reg;
  // Idle includes the exit cycle, where a start is accepted
  wire          take = start && !busy;
  // Operands as an accepted start should leave them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_q <= {PW{1'b0}};
      r_q <= {AW{1'b0}};
      n_q <= 12'h0;
      d_q <= 1'h0;
    end else if (take) begin
      p_q <= instr_addr;
      r_q <= field_addr + ix;
      n_q <= search_len;
      d_q <= delimited;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    take;
  endsequence
  sequence s_empty_exit;
    !mem_req ##1 next_instr_fetch && !found;
  endsequence
  AST_FIRST_ADDR: assert property (s_take and search_len != 12'h0
    |-> ##2 mem_req && mem_addr == r_q) else $error("bad first address");
  AST_ONE_READ: assert property (mem_req |=> !mem_req)
    else $error("read strobe too long");
  AST_NO_IDLE_READ: assert property (!busy |-> !mem_req)
    else $error("read while idle");
  AST_BUSY: assert property (s_take |=> busy && !next_instr_fetch)
    else $error("start not taken");
  AST_EXIT: assert property (next_instr_fetch
    |-> next_addr == p_q + (found ? 3'h4 : 3'h3) && count_we && !busy)
    else $error("bad exit address");
  AST_MISS_LEN: assert property (next_instr_fetch && !found && !d_q
    |-> count_index_reg[11:0] == n_q) else $error("bad miss count");
  AST_TOP: assert property (count_we |-> count_index_reg[14:12] == 3'h0)
    else $error("top count bits set");
  AST_ZERO_LEN: assert property (s_take and search_len == 12'h0
    |-> ##1 s_empty_exit) else $error("empty field not immediate");
endmodule

bind cfs_scan cfs_scan_props #(.AW(AW), .PW(PW)) props_i (.clk(clk),
  .nrst(nrst), .start(start), .delimited(delimited),
  .instr_addr(instr_addr), .field_addr(field_addr),
  .index_select_flag(index_select_flag), .first_index_reg(first_index_reg),
  .second_index_reg(second_index_reg), .search_len(search_len),
  .mem_req(mem_req), .mem_addr(mem_addr), .busy(busy),
  .next_instr_fetch(next_instr_fetch), .next_addr(next_addr),
  .count_we(count_we), .count_index_reg(count_index_reg), .found(found));

//--- test/cfs_store.sv
// Purpose: Character storage model for the scan unit
// Assumes: One read outstanding, latency chosen by the bench
// Notes:   Data line toggles between answers, never stale
`timescale 1ns/1ns
module cfs_store (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  // Read port
  input wire        mem_req,
  input wire [19:0] mem_addr,
  input wire [3:0]  lat,
  output reg        mem_ack,
  output reg [5:0]  mem_rdata
);
  reg [5:0] mem [0:63];
  reg [5:0] a;
  reg [3:0] n;
  reg       pend;
  // One answer per read after lat wait cycles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'h0;
      pend <= 1'h0;
      n <= 4'h0;
      a <= 6'h0;
      mem_rdata <= 6'h15;
    end else begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && lat == 4'h0) begin
        mem_ack <= 1'h1;
        mem_rdata <= mem[mem_addr[5:0]];
      end else if (mem_req) begin
        pend <= 1'h1;
        n <= lat - 4'h1;
        a <= mem_addr[5:0];
      end else if (pend && n == 4'h0) begin
        pend <= 1'h0;
        mem_ack <= 1'h1;
        mem_rdata <= mem[a];
      end else if (pend)
        n <= n - 4'h1;
    end
  end
endmodule

//--- test/cfs_scan_bench.sv
// Purpose: Self-checking bench of the character field scan unit
// Assumes: Storage model holds a small field at low addresses
// Notes:   Expected exits and counts worked out by hand per scan
`timescale 1ns/1ns
module cfs_scan_bench;
  reg         clk, nrst, start, ltr, neq, dlm;
  reg  [17:0] p;
  reg  [19:0] r;
  reg  [1:0]  sel;
  reg  [14:0] x1, x2;
  reg  [5:0]  scan_c, delim_c;
  reg  [11:0] len;
  reg  [3:0]  lat;
  wire        req, ack, nif, busy, we, found;
  wire [19:0] ma;
  wire [5:0]  rd;
  wire [17:0] na;
  wire [14:0] cnt;
  integer     miscompares, tests_run, i;
  cfs_scan dut (.clk(clk), .nrst(nrst), .start(start), .instr_addr(p),
    .field_addr(r), .index_select_flag(sel), .first_index_reg(x1),
    .second_index_reg(x2), .scan_char(scan_c), .delimit_char(delim_c),
    .search_len(len), .left_to_right(ltr), .unequal_test(neq),
    .delimited(dlm), .mem_req(req), .mem_addr(ma), .mem_ack(ack),
    .mem_rdata(rd), .busy(busy), .next_instr_fetch(nif), .next_addr(na),
    .count_we(we), .count_index_reg(cnt), .found(found));
  cfs_store st (.clk(clk), .nrst(nrst), .mem_req(req), .mem_addr(ma),
    .lat(lat), .mem_ack(ack), .mem_rdata(rd));
  task chk(input string n, input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %0h seen %0h", n, e, s);
      end
    end
  endtask
  task wrap_up;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // One scan; m is {left_to_right, unequal_test, delimited}
  task scan(input [1:0] s, input [19:0] a, input [11:0] n, input [5:0] c,
    input [5:0] d, input [2:0] m, input h, input [11:0] k);
    integer t;
    begin
      @(posedge clk);
      start <= 1'h1;
      sel <= s;
      r <= a;
      len <= n;
      // Unused instruction bits have no port, so they stay zero
      scan_c <= c;
      delim_c <= d;
      {ltr, neq, dlm} <= m;
      lat <= lat + 4'h1;
      @(posedge clk);
      start <= 1'h0;
      t = 0;
      while (nif !== 1'h1 && t < 400) begin
        @(posedge clk);
        t = t + 1;
      end
      chk("finished", t < 400, 1);
      chk("exit", na, p + (h ? 18'h4 : 18'h3));
      chk("found", found, h);
      chk("count", cnt[11:0], k);
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    {nrst, start, ltr, neq, dlm, sel, scan_c, delim_c, len, r, lat} = 0;
    p = 18'h100;
    x1 = 15'h7;
    x2 = 15'h8;
    for (i = 0; i < 64; i = i + 1)
      st.mem[i] = 6'h3f;
    st.mem[10] = 6'h05;
    st.mem[11] = 6'h0a;
    st.mem[12] = 6'h1a;
    st.mem[13] = 6'h2a;
    st.mem[14] = 6'h00;
    st.mem[15] = 6'h05;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    scan(2'h0, 20'hb, 12'h4, 6'h00, 6'h00, 3'h4, 1'h1, 12'h3);
    scan(2'h0, 20'ha, 12'h6, 6'h07, 6'h00, 3'h4, 1'h0, 12'h6);
    scan(2'h1, 20'h4, 12'h3, 6'h1a, 6'h00, 3'h4, 1'h1, 12'h1);
    scan(2'h3, 20'h4, 12'h3, 6'h1a, 6'h00, 3'h4, 1'h1, 12'h1);
    scan(2'h2, 20'h4, 12'h3, 6'h1a, 6'h00, 3'h4, 1'h1, 12'h0);
    scan(2'h0, 20'h4, 12'h3, 6'h1a, 6'h00, 3'h4, 1'h0, 12'h3);
    scan(2'h0, 20'hf, 12'h6, 6'h0a, 6'h00, 3'h0, 1'h1, 12'h4);
    scan(2'h0, 20'ha, 12'h6, 6'h00, 6'h1a, 3'h5, 1'h0, 12'h2);
    scan(2'h0, 20'ha, 12'h6, 6'h05, 6'h05, 3'h5, 1'h1, 12'h0);
    scan(2'h0, 20'h4, 12'h8, 6'h3f, 6'h00, 3'h6, 1'h1, 12'h6);
    scan(2'h0, 20'he, 12'h1, 6'h00, 6'h00, 3'h6, 1'h0, 12'h1);
    scan(2'h0, 20'hb, 12'h1, 6'h00, 6'h00, 3'h6, 1'h1, 12'h0);
    scan(2'h0, 20'ha, 12'h0, 6'h05, 6'h00, 3'h4, 1'h0, 12'h0);
    wrap_up;
  end
  // Hang guard, far beyond the longest scan sequence
  initial begin
    #400000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule
